// File: pkg/pmcs_pkg.sv
// Purpose: Constants for the power mode and clock switch block
// Assumes: One 20 MHz clock, Avalon-MM register access
// Notes: Offsets are byte addresses of 32-bit words
//
// Notes on behaviour
// - Halt select bit 7, source select bits 1:0
// - Source 00 selects the primary clock
// - Source 01: secondary clock, primary stops
// - Upper source bit selects internal, primary stops
// - Source change starts switch once source runs
// - Halt: sleep if select 0, idle if 1
// - Each halt samples halt select anew
// - Switch takes two old, four new cycles
// - Status flags at control bits 3, 2 and second control bits 6, 4
// - Flags encode the active clock source
// - Internal as primary sets both flags
// - Reset starts in primary run mode, or with TWO_SPEED runs the low internal source first
// - Force-on bit starts secondary oscillator early
// - Secondary to primary waits for primary ready
// - Frequency select write acts at once
// - Frequency 000, high clear: low-frequency source
// - Stable flag follows mid-frequency select
// - Clocks continue while internal output stabilises
// - Internal to primary waits for primary ready
// - Watchdog or monitor keeps low-frequency source on
// - Sleep stops oscillator, clears status flags
`default_nettype none

package pmcs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CTRL2 = 4'h4;
    localparam logic [3:0] OFF_CFG = 4'h8;
    localparam logic [3:0] OFF_MODE = 4'hc;
    // Control register fields
    localparam int B_HALT = 7;
    localparam int B_FREQ = 4;
    localparam int B_PRIF = 3;
    localparam int B_HFF = 2;
    localparam int B_SRC = 0;
    // Second control register fields
    localparam int B_SECF = 6;
    localparam int B_MFF = 4;
    localparam int B_FORCE = 3;
    localparam int B_MIDSEL = 1;
    localparam int B_HISEL = 0;
    // Configuration register fields
    localparam int B_PRIINT = 0;
    localparam int B_WDT = 1;
    localparam int B_FSCM = 2;
    localparam logic [7:0] RST_REG = 8'h00;
    // ------------------------------------------------------------
    // Sources, mux codes and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_PRI = 2'h0,
        SRC_SEC = 2'h1,
        SRC_INT = 2'h2
    } pmcs_src_t;
    localparam logic [3:0] MUX_PRI = 4'h1;
    localparam logic [3:0] MUX_SEC = 4'h2;
    localparam logic [3:0] MUX_HF = 4'h4;
    localparam logic [3:0] MUX_LF = 4'h8;
    localparam logic [3:0] MUX_OFF = 4'h0;
    localparam logic [2:0] OLD_CYC = 3'h2;
    localparam logic [2:0] NEW_CYC = 3'h4;
    typedef enum logic [6:0] {
        ST_RUN = 7'h01,
        ST_WAIT = 7'h02,
        ST_STOP = 7'h04,
        ST_START = 7'h08,
        ST_SLEEP = 7'h10,
        ST_IDLE = 7'h20,
        ST_WAKE = 7'h40
    } pmcs_state_t;
endpackage : pmcs_pkg

`default_nettype wire

// File: verilog/pmcs_top.sv
// Purpose: Power mode selection and glitch-free clock source switch
// Assumes: Oscillator ready pins are asynchronous to mclk
// Notes: clk_sel is one-hot gate enables for the external mux
`default_nettype none

module pmcs_top #(
    parameter bit TWO_SPEED = 1'b0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire logic pri_osc_ready,
    input wire logic sec_osc_ready,
    input wire logic int_osc_stable,
    output logic pri_osc_en,
    output logic sec_osc_en,
    output logic int_osc_en,
    output logic lf_osc_en,
    output logic [3:0] clk_sel,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [2:0] int_freq_sel,
    output logic mid_freq_sel
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pmcs_pkg::pmcs_state_t st;
        pmcs_pkg::pmcs_src_t cur;
        pmcs_pkg::pmcs_src_t tgt;
        logic [2:0] cnt;
        logic [3:0] mux;
        logic halt_sel;
        logic [2:0] freq;
        logic [1:0] src_sel;
        logic force_on;
        logic mid_sel;
        logic hi_sel;
        logic pri_int;
        logic wdt_en;
        logic fscm_en;
        logic sec_kept;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] filt;
        logic ack;
        logic [31:0] rdata;
    } pmcs_reg_t;

    pmcs_reg_t q;
    pmcs_reg_t n;
    pmcs_pkg::pmcs_src_t want;
    logic live;
    logic busy;
    logic int_req;
    logic int_ok;
    logic primary_clock_active_flag;
    logic hf_any;
    logic high_freq_internal_stable_flag;
    logic mid_freq_internal_stable_flag;
    logic secondary_clock_active_flag;
    logic head_pri;
    logic head_sec;
    logic head_int;
    logic tgt_rdy;
    logic bus_req;
    logic [7:0] ctrl_rd;
    logic [7:0] ctrl2_rd;

    // Gate code for a source
    function automatic logic [3:0] mux_of(pmcs_pkg::pmcs_src_t s, logic ireq);
        logic [3:0] m;
        m = pmcs_pkg::MUX_PRI;
        if (s == pmcs_pkg::SRC_SEC) begin
            m = pmcs_pkg::MUX_SEC;
        end else if (s == pmcs_pkg::SRC_INT) begin
            m = ireq ? pmcs_pkg::MUX_HF : pmcs_pkg::MUX_LF;
        end
        return m;
    endfunction : mux_of

    // ------------------------------------------------------------
    // Status decode
    // ------------------------------------------------------------
    // Upper bit wins, lower ignored for internal
    assign want = q.src_sel[1] ? pmcs_pkg::SRC_INT :
        (q.src_sel[0] ? pmcs_pkg::SRC_SEC : pmcs_pkg::SRC_PRI);
    assign live = (q.st != pmcs_pkg::ST_SLEEP) && (q.st != pmcs_pkg::ST_WAKE);
    assign busy = (q.st == pmcs_pkg::ST_WAIT) || (q.st == pmcs_pkg::ST_STOP) ||
        (q.st == pmcs_pkg::ST_START) || (q.st == pmcs_pkg::ST_WAKE);
    assign int_req = (|q.freq) | q.hi_sel;
    assign int_ok = int_req & q.filt[2];
    // Flags follow the source in use, cleared while asleep
    assign primary_clock_active_flag = live && (q.cur == pmcs_pkg::SRC_PRI);
    assign hf_any = live && int_ok && ((q.cur == pmcs_pkg::SRC_INT) ||
        ((q.cur == pmcs_pkg::SRC_PRI) && q.pri_int));
    assign high_freq_internal_stable_flag = hf_any && !q.mid_sel;
    assign mid_freq_internal_stable_flag = hf_any && q.mid_sel;
    assign secondary_clock_active_flag = live && (q.cur == pmcs_pkg::SRC_SEC);

    // Oscillator demand: current source or pending target
    assign head_pri = (live && !busy && q.cur == pmcs_pkg::SRC_PRI) ||
        (busy && q.tgt == pmcs_pkg::SRC_PRI) ||
        ((q.st == pmcs_pkg::ST_WAIT || q.st == pmcs_pkg::ST_STOP) &&
        q.cur == pmcs_pkg::SRC_PRI);
    assign head_sec = (live && q.cur == pmcs_pkg::SRC_SEC) ||
        (busy && q.tgt == pmcs_pkg::SRC_SEC);
    assign head_int = (live && q.cur == pmcs_pkg::SRC_INT) ||
        (busy && q.tgt == pmcs_pkg::SRC_INT);
    assign pri_osc_en = head_pri;
    // Secondary kept after leaving it, or forced on
    assign sec_osc_en = head_sec | q.force_on | q.sec_kept;
    assign int_osc_en = int_req & (head_int | (head_pri & q.pri_int));
    assign lf_osc_en = (head_int & !int_req) | q.wdt_en | q.fscm_en;
    // Internal path always has a clock, so no wait
    assign tgt_rdy = (q.tgt == pmcs_pkg::SRC_PRI) ? q.filt[0] :
        ((q.tgt == pmcs_pkg::SRC_SEC) ? q.filt[1] : 1'b1);
    assign clk_sel = q.mux;
    assign cpu_clk_en = live && (q.st != pmcs_pkg::ST_IDLE);
    assign periph_clk_en = live;
    assign int_freq_sel = q.freq;
    assign mid_freq_sel = q.mid_sel;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    // One wait cycle, then answer with registered data
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & !q.ack;
    assign avs_readdata = q.rdata;
    assign ctrl_rd = {q.halt_sel, q.freq, primary_clock_active_flag, high_freq_internal_stable_flag, q.src_sel};
    assign ctrl2_rd = {1'b0, secondary_clock_active_flag, 1'b0, mid_freq_internal_stable_flag, q.force_on, 1'b0, q.mid_sel,
        q.hi_sel};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        // Three-stage sync; value moves when stages two and three agree
        n.s1 = {int_osc_stable, sec_osc_ready, pri_osc_ready};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));
        n.ack = bus_req & !q.ack;
        if (bus_req && !q.ack) begin
            case (avs_address)
                pmcs_pkg::OFF_CTRL: n.rdata = {24'h000000, ctrl_rd};
                pmcs_pkg::OFF_CTRL2: n.rdata = {24'h000000, ctrl2_rd};
                pmcs_pkg::OFF_CFG: n.rdata = {29'h00000000, q.fscm_en, q.wdt_en, q.pri_int};
                pmcs_pkg::OFF_MODE: n.rdata = {25'h0000000, q.st};
                default: n.rdata = 32'h00000000;
            endcase
        end
        // Write lands on the edge after the wait cycle, once waitrequest is low
        if (q.ack && avs_write && avs_byteenable[0]) begin
            case (avs_address)
                pmcs_pkg::OFF_CTRL: begin
                    n.halt_sel = avs_writedata[pmcs_pkg::B_HALT];
                    n.freq = avs_writedata[pmcs_pkg::B_FREQ +: 3];
                    n.src_sel = avs_writedata[pmcs_pkg::B_SRC +: 2];
                end
                pmcs_pkg::OFF_CTRL2: begin
                    n.force_on = avs_writedata[pmcs_pkg::B_FORCE];
                    n.mid_sel = avs_writedata[pmcs_pkg::B_MIDSEL];
                    n.hi_sel = avs_writedata[pmcs_pkg::B_HISEL];
                end
                pmcs_pkg::OFF_CFG: begin
                    n.pri_int = avs_writedata[pmcs_pkg::B_PRIINT];
                    n.wdt_en = avs_writedata[pmcs_pkg::B_WDT];
                    n.fscm_en = avs_writedata[pmcs_pkg::B_FSCM];
                end
                default: n.halt_sel = q.halt_sel;
            endcase
        end
        if (live && q.cur == pmcs_pkg::SRC_SEC) begin
            n.sec_kept = 1'b1;
        end
        case (q.st)
            pmcs_pkg::ST_RUN: begin
                // Frequency select acts on the mux at once
                n.mux = mux_of(q.cur, int_req);
                if (halt_exec) begin
                    if (q.halt_sel) begin
                        n.st = pmcs_pkg::ST_IDLE;
                    end else begin
                        n.st = pmcs_pkg::ST_SLEEP;
                        n.mux = pmcs_pkg::MUX_OFF;
                        n.sec_kept = 1'b0;
                    end
                end else if (want != q.cur) begin
                    n.tgt = want;
                    n.st = pmcs_pkg::ST_WAIT;
                end
            end
            pmcs_pkg::ST_WAIT: begin
                // Old clock keeps running until the new one is ready
                n.tgt = want;
                if (want == q.cur) begin
                    n.st = pmcs_pkg::ST_RUN;
                end else if (tgt_rdy) begin
                    n.st = pmcs_pkg::ST_STOP;
                    n.cnt = 3'h0;
                end
            end
            pmcs_pkg::ST_STOP: begin
                // Two more old cycles, then gate it low
                n.cnt = q.cnt + 3'h1;
                if (q.cnt == pmcs_pkg::OLD_CYC - 3'h1) begin
                    n.mux = pmcs_pkg::MUX_OFF;
                    n.cnt = 3'h0;
                    n.st = pmcs_pkg::ST_START;
                end
            end
            pmcs_pkg::ST_START: begin
                // Dead gap covers the new clock sync cycles
                n.cnt = q.cnt + 3'h1;
                if (q.cnt == pmcs_pkg::NEW_CYC - 3'h1) begin
                    n.mux = mux_of(q.tgt, int_req);
                    n.cur = q.tgt;
                    n.cnt = 3'h0;
                    n.st = pmcs_pkg::ST_RUN;
                end
            end
            pmcs_pkg::ST_SLEEP: begin
                if (wake_event) begin
                    n.tgt = want;
                    n.st = pmcs_pkg::ST_WAKE;
                end
            end
            pmcs_pkg::ST_WAKE: begin
                // No clock until the selected source is ready
                n.tgt = want;
                if (tgt_rdy) begin
                    n.cnt = 3'h0;
                    n.st = pmcs_pkg::ST_START;
                end
            end
            pmcs_pkg::ST_IDLE: begin
                n.mux = mux_of(q.cur, int_req);
                if (wake_event) begin
                    n.st = pmcs_pkg::ST_RUN;
                end
            end
            default: n.st = pmcs_pkg::ST_RUN;
        endcase
    end

    // Two-speed start runs from the low internal source first
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.st <= TWO_SPEED ? pmcs_pkg::ST_WAIT : pmcs_pkg::ST_RUN;
            q.cur <= TWO_SPEED ? pmcs_pkg::SRC_INT : pmcs_pkg::SRC_PRI;
            q.tgt <= pmcs_pkg::SRC_PRI;
            q.mux <= TWO_SPEED ? pmcs_pkg::MUX_LF : pmcs_pkg::MUX_PRI;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    AST_MUX_ONEHOT: assert property ($onehot0(clk_sel))
        else $error("clock mux drives two sources");
    AST_MUX_GAP: assert property ((q.st != pmcs_pkg::ST_RUN && clk_sel != 4'h0 &&
        $past(clk_sel) != 4'h0) |-> clk_sel == $past(clk_sel))
        else $error("clock mux changed without a gap");
    AST_SWITCH_TIME: assert property ($rose(q.st == pmcs_pkg::ST_STOP) |->
        clk_sel != 4'h0 ##1 clk_sel != 4'h0 ##1 (clk_sel == 4'h0) [*4]
        ##1 clk_sel != 4'h0)
        else $error("switch timing wrong");
    AST_HALT_SLEEP: assert property ((q.st == pmcs_pkg::ST_RUN && halt_exec &&
        !q.halt_sel) |=> (!periph_clk_en && !primary_clock_active_flag && !high_freq_internal_stable_flag && !secondary_clock_active_flag))
        else $error("halt did not sleep");
    AST_HALT_IDLE: assert property ((q.st == pmcs_pkg::ST_RUN && halt_exec &&
        q.halt_sel) |=> (!cpu_clk_en && periph_clk_en && clk_sel != 4'h0))
        else $error("halt did not idle");
    AST_SEC_FLAGS: assert property ((q.st == pmcs_pkg::ST_RUN &&
        q.cur == pmcs_pkg::SRC_SEC) |-> (secondary_clock_active_flag && !primary_clock_active_flag && !pri_osc_en))
        else $error("secondary run flags wrong");
    AST_PRI_OFF: assert property ((q.st == pmcs_pkg::ST_RUN &&
        q.cur == pmcs_pkg::SRC_INT) |-> (!pri_osc_en && !primary_clock_active_flag))
        else $error("primary left on in internal run");
    AST_LF_KEEP: assert property ((q.wdt_en || q.fscm_en) |-> lf_osc_en)
        else $error("low source stopped");
    AST_SEC_KEEP: assert property (($past(q.cur) == pmcs_pkg::SRC_SEC &&
        q.cur == pmcs_pkg::SRC_PRI) |-> (sec_osc_en && primary_clock_active_flag && !secondary_clock_active_flag))
        else $error("secondary stopped after switch");
    AST_BUS_WAIT: assert property ((bus_req && avs_waitrequest) |=>
        !avs_waitrequest)
        else $error("bus wait longer than one cycle");
endmodule : pmcs_top

`default_nettype wire

// File: sim/pmcs_osc_model.sv
// Purpose: Oscillator sources on the far side of the clock switch
// Assumes: Start-up delays counted in mclk cycles
// Notes: Ready falls on the next mclk edge after an enable falls
`default_nettype none

module pmcs_osc_model #(
    parameter int PRI_DLY = 24,
    parameter int SEC_DLY = 16,
    parameter int INT_DLY = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pri_osc_en,
    input wire logic sec_osc_en,
    input wire logic int_osc_en,
    output logic pri_osc_ready,
    output logic sec_osc_ready,
    output logic int_osc_stable
);
    timeunit 1ns;
    timeprecision 1ns;
    int pri_cnt;
    int sec_cnt;
    int int_cnt;
    // ------------------------------------------------------------
    // Start-up counters
    // ------------------------------------------------------------
    // Primary already runs out of reset; no source is ready the cycle it starts
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pri_cnt <= PRI_DLY;
            sec_cnt <= 0;
            int_cnt <= 0;
        end else begin
            pri_cnt <= pri_osc_en ? ((pri_cnt < PRI_DLY) ? pri_cnt + 1 : pri_cnt) : 0;
            sec_cnt <= sec_osc_en ? ((sec_cnt < SEC_DLY) ? sec_cnt + 1 : sec_cnt) : 0;
            int_cnt <= int_osc_en ? ((int_cnt < INT_DLY) ? int_cnt + 1 : int_cnt) : 0;
        end
    end
    // Ready only when running, so a switch waits for it
    assign pri_osc_ready = (pri_cnt >= PRI_DLY);
    assign sec_osc_ready = (sec_cnt >= SEC_DLY);
    assign int_osc_stable = (int_cnt >= INT_DLY);
endmodule : pmcs_osc_model

`default_nettype wire

// File: sim/pmcs_top_tb.sv
// Purpose: Self-checking bench for the power mode clock switch
// Assumes: Oscillator model answers with fixed start-up delays
// Notes: Register access over Avalon-MM with one wait cycle
`default_nettype none

module pmcs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic halt_exec = 1'b0;
    logic wake_event = 1'b0;
    logic pri_osc_ready, sec_osc_ready, int_osc_stable;
    logic pri_osc_en, sec_osc_en, int_osc_en, lf_osc_en;
    logic [3:0] clk_sel;
    logic cpu_clk_en, periph_clk_en, mid_freq_sel;
    logic [2:0] int_freq_sel;
    logic [31:0] rd;
    int num_errors = 0;
    int checked = 0;

    // ------------------------------------------------------------
    // Clock, instances and watchdog
    // ------------------------------------------------------------
    always #25 mclk = ~mclk;
    pmcs_top pmcs_top_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .halt_exec(halt_exec), .wake_event(wake_event),
        .pri_osc_ready(pri_osc_ready), .sec_osc_ready(sec_osc_ready),
        .int_osc_stable(int_osc_stable), .pri_osc_en(pri_osc_en), .sec_osc_en(sec_osc_en),
        .int_osc_en(int_osc_en), .lf_osc_en(lf_osc_en), .clk_sel(clk_sel),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .int_freq_sel(int_freq_sel), .mid_freq_sel(mid_freq_sel));
    pmcs_osc_model pmcs_osc_model_i (.mclk(mclk), .reset_n(reset_n),
        .pri_osc_en(pri_osc_en), .sec_osc_en(sec_osc_en), .int_osc_en(int_osc_en),
        .pri_osc_ready(pri_osc_ready), .sec_osc_ready(sec_osc_ready),
        .int_osc_stable(int_osc_stable));
    // Whole run needs about 300 cycles; cut off well beyond
    initial begin
        #1_000_000;
        num_errors++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until waitrequest is sampled low; values taken settled before that edge
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data);
        logic w;
        @(posedge mclk);
        avs_address <= addr;
        avs_writedata <= {24'h0, data};
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(negedge mclk);
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge mclk);
        end while (w);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Leave callers at a settled point of the cycle
        @(negedge mclk);
    endtask : bus
    task automatic reg_check(input string what, input logic [3:0] addr, input logic [7:0] exp);
        bus(1'b0, addr, 8'h00);
        check(what, rd, {24'h0, exp});
    endtask : reg_check
    // Counts all-gated cycles until the expected gate shows
    task automatic switch_to(input logic [3:0] exp, input int gap);
        int n;
        n = 0;
        for (int i = 0; i < 600 && clk_sel !== exp; i++) begin
            @(negedge mclk);
            if (clk_sel === 4'h0) n++;
        end
        check("gap", 32'(n), 32'(gap));
        check("gate", clk_sel, exp);
    endtask : switch_to
    task automatic pulse(input logic halt);
        @(posedge mclk);
        if (halt) halt_exec <= 1'b1;
        else wake_event <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b0;
        wake_event <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask : pulse
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        reg_check("mode", 4'hc, 8'h01);
        reg_check("ctrl", 4'h0, 8'h08);
        check("gate", clk_sel, 4'h1);
        reg_check("unmapped", 4'h2, 8'h00);
        avs_byteenable <= 4'h0;
        bus(1'b1, 4'h0, 8'h80);
        avs_byteenable <= 4'hf;
        reg_check("lane off", 4'h0, 8'h08);
        $display("test reset done");
    endtask : test_reset
    task automatic test_secondary();
        bus(1'b1, 4'h4, 8'h08);
        check("sec en", sec_osc_en, 1'b1);
        repeat (30) @(posedge mclk);
        bus(1'b1, 4'h0, 8'h01);
        switch_to(4'h2, 4);
        check("pri en", pri_osc_en, 1'b0);
        reg_check("ctrl", 4'h0, 8'h01);
        reg_check("ctrl2", 4'h4, 8'h48);
        bus(1'b1, 4'h0, 8'h00);
        repeat (10) @(posedge mclk);
        check("hold sec", clk_sel, 4'h2);
        switch_to(4'h1, 4);
        reg_check("ctrl2", 4'h4, 8'h08);
        check("sec stays", sec_osc_en, 1'b1);
        $display("test secondary done");
    endtask : test_secondary
    task automatic test_internal();
        bus(1'b1, 4'h8, 8'h02);
        bus(1'b1, 4'h0, 8'h02);
        switch_to(4'h8, 4);
        reg_check("lf flags", 4'h0, 8'h02);
        check("int off", int_osc_en, 1'b0);
        bus(1'b1, 4'h0, 8'h32);
        switch_to(4'h4, 0);
        check("freq", int_freq_sel, 3'h3);
        repeat (30) @(posedge mclk);
        reg_check("hf flag", 4'h0, 8'h36);
        bus(1'b1, 4'h4, 8'h0a);
        reg_check("mf flag", 4'h4, 8'h1a);
        check("mid sel", mid_freq_sel, 1'b1);
        check("int on", int_osc_en, 1'b1);
        check("clock on", cpu_clk_en, 1'b1);
        bus(1'b1, 4'h0, 8'h30);
        switch_to(4'h1, 4);
        reg_check("ctrl", 4'h0, 8'h38);
        check("lf on", lf_osc_en, 1'b1);
        $display("test internal done");
    endtask : test_internal
    task automatic test_halt();
        bus(1'b1, 4'h0, 8'h80);
        pulse(1'b1);
        check("idle cpu", cpu_clk_en, 1'b0);
        check("idle per", periph_clk_en, 1'b1);
        reg_check("idle flags", 4'h0, 8'h88);
        pulse(1'b0);
        check("wake cpu", cpu_clk_en, 1'b1);
        bus(1'b1, 4'h0, 8'h00);
        pulse(1'b1);
        check("sleep per", periph_clk_en, 1'b0);
        check("sleep gate", clk_sel, 4'h0);
        check("sleep pri", pri_osc_en, 1'b0);
        reg_check("sleep flags", 4'h0, 8'h00);
        pulse(1'b0);
        // Ready passes the pin sync, then the gap of new-clock cycles
        wait (pri_osc_ready === 1'b1);
        repeat (5) @(negedge mclk);
        switch_to(4'h1, 4);
        reg_check("mode", 4'hc, 8'h01);
        $display("test halt done");
    endtask : test_halt

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        test_reset();
        test_secondary();
        test_internal();
        test_halt();
        complete_run();
    end
endmodule : pmcs_top_tb

`default_nettype wire
